// file: radio_irq_pkg.sv
package radio_irq_pkg;
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_POWER = 8'h04;
    localparam logic [7:0] ADDR_GENERAL = 8'h08;
    localparam logic [7:0] ADDR_RECEIVER = 8'h0C;
    localparam logic [7:0] ADDR_BATTERY = 8'h10;
    localparam logic [7:0] ADDR_FIFO = 8'h14;
    localparam logic [7:0] ADDR_BASEBAND = 8'h18;
    localparam logic [7:0] ADDR_TXBYTE = 8'h1C;
    localparam logic [7:0] ADDR_RXDATA = 8'h20;
    localparam logic [7:0] ADDR_WAKE = 8'h24;
    // power_mgmt_config fields
    localparam int PM_RECEIVER_EN = 7;
    localparam int PM_TRANSMITTER_EN = 5;
    localparam int PM_LOWBATT_EN = 2;
    localparam int PM_WAKE_EN = 1;
    localparam int PM_CLOCK_OUT_EN = 0;
    localparam int PM_OSC_EN = 3;
    // general_config, receiver, fifo and baseband config fields
    localparam int GC_TX_LATCH_EN = 7;
    localparam int GC_RX_FIFO_EN = 6;
    localparam int RC_EXT_SELECT = 10;
    localparam int FS_THRESH_LSB = 4;
    localparam int BB_DIGITAL = 4;
    localparam int BB_CR_LSB = 6;
    // status_word bit positions
    localparam int ST_TX_RX = 15;
    localparam int ST_POR = 14;
    localparam int ST_UNDER_OVER = 13;
    localparam int ST_WAKE = 12;
    localparam int ST_EXT = 11;
    localparam int ST_LOWBATT = 10;
    localparam int RX_FIFO_BITS = 16;
    localparam int FILTER_RATIO = 29;
    localparam int TAIL_NS = 2000;
    localparam int CLK_NS = 40;
    localparam int TAIL_CYCLES = (TAIL_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [31:0] POWER_RESET = 32'h0000_0009;
    localparam logic [31:0] RECEIVER_RESET = 32'h0000_0400;
    localparam logic [31:0] FIFO_RESET = 32'h0000_0080;
    localparam logic [31:0] WAKE_RESET = 32'h0000_0100;
    localparam logic [31:0] RATE_RESET = 32'h0000_0023;
    typedef enum logic [1:0] {CR_AUTO, CR_SLOW, CR_FAST, CR_AUTO2} cr_mode_type;
    typedef enum {PW_SLEEP, PW_ACTIVE, PW_TAIL} power_state_type;
    typedef struct packed {
        logic rx_bit;
        logic rx_bit_valid;
        logic tx_byte_done;
        logic supply_low;
        logic ext_irq_n;
        logic valid_fsk;
    } radio_in_type;
endpackage

// file: radio_interrupt_wake_logic.sv
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
module radio_interrupt_wake_logic
#(
    parameter int WAKE_WIDTH = 16,
    parameter int RATE_WIDTH = 16
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire radio_irq_pkg::radio_in_type radio_in,
    output logic irq_out_n,
    output logic crystal_run,
    output logic recovered_clock_pin,
    output logic filter_clk_en,
    output logic [1:0] cr_mode_active,
    output logic wake_rx_request
);
    import radio_irq_pkg::*;

    if (WAKE_WIDTH < 2 || WAKE_WIDTH > 32 || RATE_WIDTH < 2 || RATE_WIDTH > 32)
    begin : gen_width_check
        $error("unsupported width parameter");
    end

    logic [31:0] power_reg, general_reg, receiver_reg, battery_reg, fifo_cfg_reg, baseband_reg, wake_reg;
    logic [7:0] tx_byte_reg;
    logic [15:0] rx_fifo_reg;
    logic [4:0] rx_count_reg;
    logic [4:0] rx_read_reg;
    logic tx_full_reg, tx_ready_reg, underrun_reg, overflow_reg, por_reg, wake_flag_reg, lowbatt_pin_reg;
    logic fifo_level_reg;
    logic [31:0] wake_count_reg;
    logic [7:0] tail_count_reg;
    power_state_type pstate_reg;
    logic [RATE_WIDTH-1:0] rate_count_reg;
    logic [4:0] filt_count_reg;
    logic rec_clk_reg;
    logic fast_lock_reg;
    logic [3:0] lock_count_reg;

    logic aw_pend_reg, w_pend_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic do_write, do_read, status_read, rx_data_read, tx_write;
    logic [31:0] status_word;
    logic tx_on, rx_on, any_pending, pin_pending, ext_flag, lowbatt_flag;
    logic [3:0] fifo_level_threshold;
    logic [31:0] wr_merged;

    assign tx_on = power_reg[PM_TRANSMITTER_EN] && general_reg[GC_TX_LATCH_EN];
    assign rx_on = power_reg[PM_RECEIVER_EN] && general_reg[GC_RX_FIFO_EN];
    assign fifo_level_threshold = fifo_cfg_reg[FS_THRESH_LSB +: 4];

    // axi4-lite write: address and data taken independently
    assign s_axi_awready = !aw_pend_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_pend_reg && !s_axi_bvalid;
    assign do_write = aw_pend_reg && w_pend_reg && !s_axi_bvalid;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_pend_reg <= 1'b0;
            w_pend_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_pend_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_pend_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_pend_reg <= 1'b0;
                w_pend_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_reg <= ADDR_WAKE && aw_addr_reg[1:0] == 2'h0 && aw_addr_reg != ADDR_STATUS
                    && aw_addr_reg != ADDR_RXDATA) ? 2'h0 : 2'h2;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (s[i])
                r[i*8 +: 8] = d[i*8 +: 8];
        return r;
    endfunction

    always_comb
    begin
        unique case (aw_addr_reg)
            ADDR_POWER: wr_merged = merge(power_reg, w_data_reg, w_strb_reg);
            ADDR_GENERAL: wr_merged = merge(general_reg, w_data_reg, w_strb_reg);
            ADDR_RECEIVER: wr_merged = merge(receiver_reg, w_data_reg, w_strb_reg);
            ADDR_BATTERY: wr_merged = merge(battery_reg, w_data_reg, w_strb_reg);
            ADDR_FIFO: wr_merged = merge(fifo_cfg_reg, w_data_reg, w_strb_reg);
            ADDR_BASEBAND: wr_merged = merge(baseband_reg, w_data_reg, w_strb_reg);
            ADDR_WAKE: wr_merged = merge(wake_reg, w_data_reg, w_strb_reg);
            default: wr_merged = w_data_reg;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            power_reg <= POWER_RESET;
            general_reg <= 32'h0000_0000;
            receiver_reg <= RECEIVER_RESET;
            battery_reg <= 32'h0000_0000;
            fifo_cfg_reg <= FIFO_RESET;
            baseband_reg <= RATE_RESET;
            wake_reg <= WAKE_RESET;
        end
        else if (do_write)
        begin
            unique case (aw_addr_reg)
                ADDR_POWER: power_reg <= wr_merged;
                ADDR_GENERAL: general_reg <= wr_merged;
                ADDR_RECEIVER: receiver_reg <= wr_merged;
                ADDR_BATTERY: battery_reg <= wr_merged;
                ADDR_FIFO: fifo_cfg_reg <= wr_merged;
                ADDR_BASEBAND: baseband_reg <= wr_merged;
                ADDR_WAKE: wake_reg <= wr_merged;
                default: ;
            endcase
        end
    end

    assign tx_write = do_write && aw_addr_reg == ADDR_TXBYTE && w_strb_reg[0];

    // axi4-lite read
    assign s_axi_arready = !s_axi_rvalid;
    assign do_read = s_axi_arvalid && s_axi_arready;
    assign status_read = do_read && s_axi_araddr == ADDR_STATUS;
    assign rx_data_read = do_read && s_axi_araddr == ADDR_RXDATA;

    assign ext_flag = !receiver_reg[RC_EXT_SELECT] && !radio_in.ext_irq_n;
    assign lowbatt_flag = power_reg[PM_LOWBATT_EN] && radio_in.supply_low;
    assign status_word = {16'h0000, tx_ready_reg || fifo_level_reg, por_reg, underrun_reg || overflow_reg,
        wake_flag_reg, ext_flag, lowbatt_flag, 10'h000};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end
        else if (do_read)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            unique case (s_axi_araddr)
                ADDR_STATUS: s_axi_rdata <= status_word;
                ADDR_POWER: s_axi_rdata <= power_reg;
                ADDR_GENERAL: s_axi_rdata <= general_reg;
                ADDR_RECEIVER: s_axi_rdata <= receiver_reg;
                ADDR_BATTERY: s_axi_rdata <= battery_reg;
                ADDR_FIFO: s_axi_rdata <= fifo_cfg_reg;
                ADDR_BASEBAND: s_axi_rdata <= baseband_reg;
                ADDR_TXBYTE: s_axi_rdata <= {24'h000000, tx_byte_reg};
                ADDR_RXDATA: s_axi_rdata <= {27'h0, rx_count_reg} << 16 | {16'h0000, rx_fifo_reg};
                ADDR_WAKE: s_axi_rdata <= wake_reg;
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // transmit holding register, ready and underrun
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_byte_reg <= 8'h00;
            tx_full_reg <= 1'b0;
            tx_ready_reg <= 1'b0;
            underrun_reg <= 1'b0;
        end
        else if (!tx_on)
        begin
            tx_full_reg <= 1'b0;
            tx_ready_reg <= 1'b0;
            underrun_reg <= 1'b0;
        end
        else
        begin
            if (tx_write)
                tx_byte_reg <= w_data_reg[7:0];
            if (radio_in.tx_byte_done && !tx_full_reg && !tx_write)
            begin
                underrun_reg <= 1'b1;
                tx_ready_reg <= 1'b1;
            end
            else if (tx_write && !underrun_reg)
                tx_ready_reg <= 1'b0;
            else if (radio_in.tx_byte_done || !tx_full_reg)
                tx_ready_reg <= 1'b1;
            if (tx_write)
                tx_full_reg <= 1'b1;
            else if (radio_in.tx_byte_done)
                tx_full_reg <= 1'b0;
        end
    end

    // receive fifo, threshold and overflow; analog mode bypasses it
    logic rx_push;
    assign rx_push = rx_on && baseband_reg[BB_DIGITAL] && radio_in.rx_bit_valid && rec_clk_reg;
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !rx_on)
        begin
            rx_fifo_reg <= 16'h0000;
            rx_count_reg <= 5'h00;
            rx_read_reg <= 5'h00;
            fifo_level_reg <= 1'b0;
            overflow_reg <= 1'b0;
        end
        else
        begin
            if (rx_data_read)
            begin
                rx_count_reg <= 5'h00;
                rx_read_reg <= rx_count_reg;
            end
            else if (rx_push)
            begin
                rx_fifo_reg <= {rx_fifo_reg[14:0], radio_in.rx_bit};
                if (rx_count_reg != 5'(RX_FIFO_BITS))
                    rx_count_reg <= rx_count_reg + 5'h01;
            end
            if (rx_push && !rx_data_read && rx_count_reg == 5'(RX_FIFO_BITS))
                overflow_reg <= 1'b1;
            else if (status_read)
                overflow_reg <= 1'b0;
            if (rx_push && !rx_data_read && rx_count_reg + 5'h01 >= {1'b0, fifo_level_threshold})
                fifo_level_reg <= 1'b1;
            else if (rx_data_read && rx_count_reg >= {1'b0, fifo_level_threshold})
                fifo_level_reg <= 1'b0;
        end
    end

    // power-on, wake timer
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            por_reg <= 1'b1;
            wake_flag_reg <= 1'b0;
            wake_count_reg <= 32'h0000_0000;
        end
        else
        begin
            if (status_read)
                por_reg <= 1'b0;
            if (!power_reg[PM_WAKE_EN])
                wake_count_reg <= 32'h0000_0000;
            else if (wake_count_reg >= {{(32 - WAKE_WIDTH){1'b0}}, wake_reg[WAKE_WIDTH-1:0]})
            begin
                wake_count_reg <= 32'h0000_0000;
                wake_flag_reg <= 1'b1;
            end
            else
                wake_count_reg <= wake_count_reg + 32'h0000_0001;
            if (status_read && !(power_reg[PM_WAKE_EN]
                && wake_count_reg >= {{(32 - WAKE_WIDTH){1'b0}}, wake_reg[WAKE_WIDTH-1:0]}))
                wake_flag_reg <= 1'b0;
        end
    end

    // low battery pin request, released by status read until re-entry
    logic lowbatt_prev_reg;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            lowbatt_pin_reg <= 1'b0;
            lowbatt_prev_reg <= 1'b0;
        end
        else
        begin
            lowbatt_prev_reg <= lowbatt_flag;
            if (lowbatt_flag && !lowbatt_prev_reg)
                lowbatt_pin_reg <= 1'b1;
            else if (status_read || !lowbatt_flag)
                lowbatt_pin_reg <= 1'b0;
        end
    end

    assign pin_pending = tx_ready_reg || fifo_level_reg || overflow_reg || por_reg || wake_flag_reg
        || ext_flag || lowbatt_pin_reg;
    assign any_pending = pin_pending;
    assign irq_out_n = !pin_pending;

    // oscillator control with clock tail
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pstate_reg <= PW_ACTIVE;
            tail_count_reg <= 8'h00;
        end
        else
        begin
            unique case (pstate_reg)
                PW_SLEEP:
                    if (any_pending || power_reg[PM_OSC_EN] || tx_on || rx_on || wake_flag_reg)
                        pstate_reg <= PW_ACTIVE;
                PW_ACTIVE:
                    if (!any_pending && !power_reg[PM_OSC_EN] && !power_reg[PM_RECEIVER_EN]
                        && !power_reg[PM_TRANSMITTER_EN])
                    begin
                        pstate_reg <= PW_TAIL;
                        tail_count_reg <= 8'(TAIL_CYCLES);
                    end
                PW_TAIL:
                    if (any_pending || power_reg[PM_OSC_EN])
                        pstate_reg <= PW_ACTIVE;
                    else if (tail_count_reg == 8'h01)
                        pstate_reg <= PW_SLEEP;
                    else
                        tail_count_reg <= tail_count_reg - 8'h01;
            endcase
        end
    end
    assign crystal_run = pstate_reg != PW_SLEEP && (power_reg[PM_CLOCK_OUT_EN] || any_pending);

    // timer wake-up asks for receive until fifo drained and flags cleared
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            wake_rx_request <= 1'b0;
        else if (power_reg[PM_WAKE_EN] && wake_count_reg >= {{(32 - WAKE_WIDTH){1'b0}}, wake_reg[WAKE_WIDTH-1:0]})
            wake_rx_request <= 1'b1;
        else if (wake_rx_request && !any_pending && rx_count_reg == 5'h00 && !radio_in.valid_fsk)
            wake_rx_request <= 1'b0;
    end

    // digital filter tick at 29x data rate and bit clock recovery
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !baseband_reg[BB_DIGITAL])
        begin
            rate_count_reg <= '0;
            filt_count_reg <= 5'h00;
            rec_clk_reg <= 1'b0;
            filter_clk_en <= 1'b0;
        end
        else
        begin
            filter_clk_en <= 1'b0;
            rec_clk_reg <= 1'b0;
            if (rate_count_reg >= RATE_WIDTH'(baseband_reg[31:16]))
            begin
                rate_count_reg <= '0;
                filter_clk_en <= 1'b1;
                if (filt_count_reg == 5'(FILTER_RATIO - 1))
                begin
                    filt_count_reg <= 5'h00;
                    rec_clk_reg <= 1'b1;
                end
                else
                    filt_count_reg <= filt_count_reg + 5'h01;
            end
            else
                rate_count_reg <= rate_count_reg + RATE_WIDTH'(1);
        end
    end

    // automatic mode: fast until locked for several bits, then slow
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !radio_in.valid_fsk)
        begin
            lock_count_reg <= 4'h0;
            fast_lock_reg <= 1'b1;
        end
        else if (rec_clk_reg)
        begin
            if (lock_count_reg == 4'hF)
                fast_lock_reg <= 1'b0;
            else
                lock_count_reg <= lock_count_reg + 4'h1;
        end
    end

    always_comb
    begin
        unique case (cr_mode_type'(baseband_reg[BB_CR_LSB +: 2]))
            CR_SLOW: cr_mode_active = 2'h1;
            CR_FAST: cr_mode_active = 2'h2;
            default: cr_mode_active = fast_lock_reg ? 2'h2 : 2'h1;
        endcase
    end

    // recovered clock visible on pin only when fifo unused; none in analog mode
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            recovered_clock_pin <= 1'b0;
        else
            recovered_clock_pin <= baseband_reg[BB_DIGITAL] && !general_reg[GC_RX_FIFO_EN] && rec_clk_reg;
    end
endmodule // radio_interrupt_wake_logic

// file: radio_irq_asserts.sv
module radio_irq_asserts
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic irq_out_n,
    input wire logic crystal_run,
    input wire logic recovered_clock_pin,
    input wire logic [1:0] cr_mode_active
);
    default clocking dc @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    por_request_a: assert property ($rose(aresetn) |-> !irq_out_n)
        else $error("no power-on request after reset");
    pending_xtal_a: assert property (!irq_out_n |-> ##[0:1] crystal_run)
        else $error("crystal stopped while request pending");
    clock_tail_a: assert property ($rose(irq_out_n) |-> crystal_run [*8])
        else $error("crystal stopped right after release");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    bvalid_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    rvalid_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during response");
    cr_mode_a: assert property (cr_mode_active != 2'h3)
        else $error("illegal recovery mode");
    rclk_pulse_a: assert property (recovered_clock_pin |=> !recovered_clock_pin)
        else $error("recovered clock pulse too long");
    cover property ($fell(irq_out_n));
    cover property ($fell(crystal_run));
    cover property (s_axi_bvalid);
endmodule // radio_irq_asserts

bind radio_interrupt_wake_logic radio_irq_asserts u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .irq_out_n,
    .crystal_run, .recovered_clock_pin, .cr_mode_active);

// file: radio_front_model.sv
module radio_front_model
(
    input wire logic aclk,
    input wire logic [4:0] n_bits,
    input wire logic go,
    input wire logic ext_n,
    input wire logic batt_low,
    input wire logic done_p,
    output radio_irq_pkg::radio_in_type radio_in
);
    timeunit 1ns;
    timeprecision 1ns;
    import radio_irq_pkg::*;
    logic [4:0] left_reg = 5'h0;
    logic [4:0] ph_reg = 5'h0;
    logic bit_reg = 1'b0;
    logic tick;
    assign tick = left_reg != 5'h0 && ph_reg == 5'(FILTER_RATIO - 1);
    // data held valid for one recovered clock period per bit; idle data line toggles every cycle
    always_ff @(posedge aclk)
    begin
        ph_reg <= (go || tick) ? 5'h0 : ph_reg + 5'h1;
        if (left_reg == 5'h0 || tick)
            bit_reg <= ~bit_reg;
        if (go)
            left_reg <= n_bits;
        else if (tick)
            left_reg <= left_reg - 5'h1;
    end
    assign radio_in = {bit_reg, left_reg != 5'h0, done_p, batt_low, ext_n, left_reg != 5'h0};
endmodule // radio_front_model

// file: tb_radio_interrupt_wake_logic.sv
module tb_radio_interrupt_wake_logic;
    timeunit 1ns;
    timeprecision 1ns;
    import radio_irq_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, cr_mode_active, r;
    logic [31:0] s_axi_rdata, d;
    radio_in_type radio_in;
    logic irq_out_n, crystal_run, recovered_clock_pin, filter_clk_en, wake_rx_request;
    logic [4:0] n_bits = 5'h0;
    logic go = 1'b0, ext_n = 1'b1, batt_low = 1'b0, done_p = 1'b0;
    int error_cnt = 0;
    int n_checks = 0;
    int pulses = 0;
    int i;
    always #20 aclk = ~aclk;
    always @(negedge aclk)
        if (recovered_clock_pin === 1'b1)
            pulses <= pulses + 1;
    radio_interrupt_wake_logic dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .radio_in,
        .irq_out_n, .crystal_run, .recovered_clock_pin, .filter_clk_en, .cr_mode_active, .wake_rx_request);
    radio_front_model peer (.aclk, .n_bits, .go, .ext_n, .batt_low, .done_p, .radio_in);
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic guard(input int k);
        if (k >= 200)
        begin
            chk(32'h0, 32'h1, "wait timed out");
            stop_test;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 200; i++)
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
                break;
        end
        guard(i);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 200; i++)
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
                break;
        end
        guard(i);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic sb(input int b, input logic v);
        rd(ADDR_STATUS);
        chk({31'h0, d[b]}, {31'h0, v}, "status flag");
    endtask
    task automatic pin(input logic v);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq_out_n}, {31'h0, v}, "request pin");
    endtask
    task automatic burst(input logic [4:0] n);
        go <= 1'b1;
        n_bits <= n;
        @(posedge aclk);
        go <= 1'b0;
        repeat (FILTER_RATIO * n + 8) @(posedge aclk);
    endtask
    task automatic pulse;
        done_p <= 1'b1;
        @(posedge aclk);
        done_p <= 1'b0;
    endtask
    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk({31'h0, crystal_run}, 32'h1, "crystal at reset");
        rd(ADDR_POWER);
        chk(d, POWER_RESET, "power reset value");
        sb(ST_POR, 1'b1);
        pin(1'b1);
        sb(ST_POR, 1'b0);
        rd(8'h40);
        chk(d, 32'h0, "unmapped read data");
        chk({30'h0, r}, 32'h2, "unmapped read response");
        wr(ADDR_STATUS, 32'h0);
        chk({30'h0, r}, 32'h2, "read-only write");
        for (int m = 1; m < 3; m++)
        begin
            wr(ADDR_BASEBAND, 32'h13 | (m << BB_CR_LSB));
            chk({30'h0, cr_mode_active}, m, "recovery mode");
        end
        wr(ADDR_RECEIVER, 32'h0);
        ext_n <= 1'b0;
        pin(1'b0);
        sb(ST_EXT, 1'b1);
        ext_n <= 1'b1;
        pin(1'b1);
        wr(ADDR_BATTERY, 32'h5);
        wr(ADDR_POWER, 32'h0D);
        batt_low <= 1'b1;
        pin(1'b0);
        sb(ST_LOWBATT, 1'b1);
        pin(1'b1);
        sb(ST_LOWBATT, 1'b1);
        batt_low <= 1'b0;
        pin(1'b1);
        sb(ST_LOWBATT, 1'b0);
        wr(ADDR_WAKE, 32'h40);
        wr(ADDR_POWER, 32'h0B);
        for (i = 0; i < 200 && irq_out_n !== 1'b0; i++)
            @(posedge aclk);
        guard(i);
        pin(1'b0);
        chk({31'h0, wake_rx_request}, 32'h1, "wake asks receive");
        sb(ST_WAKE, 1'b1);
        wr(ADDR_POWER, 32'h09);
        pin(1'b1);
        chk({31'h0, wake_rx_request}, 32'h0, "wake receive ends");
        wr(ADDR_GENERAL, 32'h80);
        wr(ADDR_POWER, 32'h29);
        pin(1'b0);
        sb(ST_TX_RX, 1'b1);
        wr(ADDR_TXBYTE, 32'hA5);
        pin(1'b1);
        pulse;
        pin(1'b0);
        pulse;
        repeat (3) @(posedge aclk);
        rd(ADDR_STATUS);
        chk(d & 32'hA000, 32'hA000, "underrun flags");
        sb(ST_UNDER_OVER, 1'b1);
        wr(ADDR_POWER, 32'h09);
        wr(ADDR_GENERAL, 32'h0);
        pin(1'b1);
        wr(ADDR_BASEBAND, 32'h33);
        chk({30'h0, cr_mode_active}, 32'h2, "auto mode starts fast");
        wr(ADDR_GENERAL, 32'h40);
        wr(ADDR_POWER, 32'h89);
        burst(5'h8);
        pin(1'b0);
        burst(5'h9);
        rd(ADDR_STATUS);
        chk(d & 32'hA000, 32'hA000, "overflow flags");
        sb(ST_UNDER_OVER, 1'b0);
        pin(1'b0);
        rd(ADDR_RXDATA);
        chk(d & 32'h1F_0000, 32'h10_0000, "fifo count");
        pin(1'b1);
        wr(ADDR_GENERAL, 32'h0);
        burst(5'h4);
        pulses = 0;
        repeat (4 * FILTER_RATIO) @(posedge aclk);
        chk(pulses, 32'h4, "recovered clock pulses");
        chk({31'h0, filter_clk_en}, 32'h1, "filter tick");
        wr(ADDR_BASEBAND, 32'h23);
        pulses = 0;
        burst(5'h4);
        chk(pulses, 32'h0, "analog mode clock");
        chk({31'h0, filter_clk_en}, 32'h0, "analog filter idle");
        wr(ADDR_POWER, 32'h01);
        repeat (10) @(posedge aclk);
        chk({31'h0, crystal_run}, 32'h1, "clock tail");
        for (i = 0; i < 200 && crystal_run !== 1'b0; i++)
            @(posedge aclk);
        guard(i);
        chk({31'h0, crystal_run}, 32'h0, "crystal off");
        ext_n <= 1'b0;
        pin(1'b0);
        chk({31'h0, crystal_run}, 32'h1, "wake on request");
        ext_n <= 1'b1;
        stop_test;
    end
endmodule // tb_radio_interrupt_wake_logic
